// ==== rtl/dtr_defines.vh ====
`ifndef DTR_DEFINES_VH
`define DTR_DEFINES_VH

// Register byte offsets
`define DTR_REG_CTRL     8'h00
`define DTR_REG_TRIG     8'h04
`define DTR_REG_THRESH   8'h08
`define DTR_REG_SAMPLE   8'h0c
`define DTR_REG_POST     8'h10
`define DTR_REG_SRCSEL   8'h14
`define DTR_REG_STATUS   8'h18
`define DTR_REG_TRIGPOS  8'h1c
`define DTR_REG_COUNT    8'h20
`define DTR_REG_IRQSTAT  8'h24
`define DTR_REG_IRQMASK  8'h28
`define DTR_REG_RDIDX    8'h2c
`define DTR_REG_RDREL    8'h30
// Channel data window 0x40..0x5c, one word per channel
`define DTR_DATA_PAGE    3'h2

// Field positions
`define DTR_TRIG_SEL_LSB  0
`define DTR_TRIG_COND_LSB 8
`define DTR_IRQ_TRIG      0
`define DTR_IRQ_DONE      1

// Geometry
`define DTR_DEPTH        128
`define DTR_CHANS        8
`define DTR_SIG_W        16
`define DTR_NUM_SIG      16
`define DTR_SEL_W        4
`define DTR_IDX_MAX      7'h7f

// Trigger condition codes
`define DTR_COND_THRESH  2'h2
`define DTR_COND_FAULT   2'h3

// Reset values and sampling interval limit
`define DTR_RST_INTERVAL 7'h01
`define DTR_RST_POST     7'h0a
`define DTR_RST_SRCSEL   32'h76543210
`define DTR_INTERVAL_MAX 7'h63

// Timing: sample point after the firing pulse
`define DTR_CLK_PERIOD_NS  25
`define DTR_SAMPLE_DLY_NS  100
// Delay in clocks, sized for the 3-bit delay counter
`define DTR_SAMPLE_DLY_CYC 3'h4

// AXI responses
`define DTR_RESP_OKAY    2'h0
`define DTR_RESP_SLVERR  2'h2

`endif

// ==== rtl/dtr_sync.v ====
`timescale 1ns/100ps
module dtr_sync (
   input  wire sys_clk,
   input  wire srst,
   input  wire asyncIn,
   output wire syncOut
);
   reg meta_q;
   reg sync_q;

   always @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;
endmodule // dtr_sync

// ==== rtl/dtr_line_mem.v ====
`timescale 1ns/100ps
`include "dtr_defines.vh"
module dtr_line_mem (
   input  wire         sys_clk,
   input  wire         wrEn,
   input  wire [6:0]   wrAddr,
   input  wire [127:0] wrLine,
   input  wire [6:0]   rdAddr,
   output wire [127:0] rdLine
);
   // Flip-flop storage, no reset: contents are only meaningful after a run
   reg [127:0] mem [0:`DTR_DEPTH-1];

   always @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrLine;
      end
   end

   assign rdLine = mem[rdAddr];
endmodule // dtr_line_mem

// ==== rtl/dtr_recorder.v ====
// Operation
// - Buffer holds 128 lines, each with up to 8 selectable signal samples.
// - Sampling interval programmable from every firing cycle to every 99th.
// - Each channel has its own source select; channels counted from zero.
// - Condition code 2 fires when trigger signal exceeds the threshold.
// - Condition code 3 fires on any fault; select and threshold ignored.
// - After trigger, record exactly the post-event count of lines, then stop.
// - On completion the recorder clears its start control by itself.
// - Writing start 0 while recording stops at once; position invalid.
// - Trigger position marked valid only if settings preceded arming.
// - All channels of a line sampled together shortly after firing pulse.
// - Readout is chronological; line 0 is trigger, earlier negative.
// - Pre-trigger lines are buffer depth minus post-event count.
// - Readable count reports how many lines per channel were captured.
// - Trigger line sits at raw index 127 minus post-event count.
`timescale 1ns/100ps
`include "dtr_defines.vh"
module dtr_recorder (
   input  wire         sys_clk,
   input  wire         srst,
   input  wire [7:0]   s_axi_awaddr,
   input  wire         s_axi_awvalid,
   output wire         s_axi_awready,
   input  wire [31:0]  s_axi_wdata,
   input  wire [3:0]   s_axi_wstrb,
   input  wire         s_axi_wvalid,
   output wire         s_axi_wready,
   output wire [1:0]   s_axi_bresp,
   output wire         s_axi_bvalid,
   input  wire         s_axi_bready,
   input  wire [7:0]   s_axi_araddr,
   input  wire         s_axi_arvalid,
   output wire         s_axi_arready,
   output wire [31:0]  s_axi_rdata,
   output wire [1:0]   s_axi_rresp,
   output wire         s_axi_rvalid,
   input  wire         s_axi_rready,
   input  wire         fireStrobe,
   input  wire [255:0] sigBus,
   input  wire         faultPin,
   output wire         irq
);
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_PRE  = 3'h2;
   localparam [2:0] ST_POST = 3'h4;

   function [31:0] mergeStrb;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0]  strb;
      integer      b;
      begin
         mergeStrb = oldVal;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               mergeStrb[b*8 +: 8] = newVal[b*8 +: 8];
            end
         end
      end
   endfunction

   function [15:0] pickSig;
      input [255:0] bus;
      input [3:0]   sel;
      begin
         pickSig = bus[{sel, 4'h0} +: 16];
      end
   endfunction

   // AXI slave state
   reg         awReady_q;
   reg         wReady_q;
   reg         awHeld_q;
   reg         wHeld_q;
   reg [7:0]   awAddr_q;
   reg [31:0]  wData_q;
   reg [3:0]   wStrb_q;
   reg         bValid_q;
   reg [1:0]   bResp_q;
   reg         arReady_q;
   reg         rValid_q;
   reg [31:0]  rData_q;
   reg [1:0]   rResp_q;

   // Settings
   reg         startCtl_q;
   reg [3:0]   trigSel_q;
   reg [1:0]   trigCond_q;
   reg [15:0]  thresh_q;
   reg [6:0]   interval_q;
   reg [6:0]   postLines_q;
   reg [31:0]  srcSel_q;
   reg [1:0]   irqMask_q;
   reg [1:0]   irqStat_q;
   reg [6:0]   rdIdx_q;

   // Recorder state
   reg [2:0]   state_q;
   reg [6:0]   wrPtr_q;
   reg [6:0]   endPtr_q;
   reg [6:0]   postLeft_q;
   reg [7:0]   count_q;
   reg [6:0]   trigPos_q;
   reg         trigPosValid_q;
   reg         triggered_q;
   reg         cfgDirty_q;
   reg [6:0]   divCnt_q;
   reg [2:0]   dlyCnt_q;
   reg         faultPend_q;
   reg         irq_q;

   wire        faultSync;
   wire [127:0] rdLine;
   reg  [127:0] capLine;
   reg  [31:0]  curWr;
   reg  [31:0]  rdVal;
   reg          rdOk;
   reg          wrOk;
   reg  [6:0]   intervalEff;

   dtr_sync u_fault_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .asyncIn (faultPin),
      .syncOut (faultSync)
   );

   wire        awTake   = s_axi_awvalid & awReady_q;
   wire        wTake    = s_axi_wvalid & wReady_q;
   wire        doWrite  = awHeld_q & wHeld_q & ~bValid_q;
   wire        arTake   = s_axi_arvalid & arReady_q;
   wire [31:0] wrVal    = mergeStrb(curWr, wData_q, wStrb_q);
   wire        isIdle   = state_q[0];
   wire        recActive = state_q[1] | state_q[2];

   wire        startWr  = doWrite & (awAddr_q == `DTR_REG_CTRL) & wStrb_q[0];
   wire        arm      = startWr & wData_q[0] & isIdle;
   wire        abort    = startWr & ~wData_q[0] & recActive;
   wire        cfgWr    = doWrite & wrOk & ~startWr &
                          (awAddr_q < `DTR_REG_STATUS);

   // Data captured in one sweep so every channel shares the same instant
   integer ch;
   always @* begin
      capLine = 128'h0;
      for (ch = 0; ch < `DTR_CHANS; ch = ch + 1) begin
         capLine[ch*16 +: 16] = pickSig(sigBus, srcSel_q[ch*4 +: 4]);
      end
   end

   always @* begin
      if (interval_q == 7'h00) begin
         intervalEff = 7'h01;
      end else if (interval_q > `DTR_INTERVAL_MAX) begin
         intervalEff = `DTR_INTERVAL_MAX;
      end else begin
         intervalEff = interval_q;
      end
   end

   wire [15:0] trigVal   = pickSig(sigBus, trigSel_q);
   wire        thrHit    = $signed(trigVal) > $signed(thresh_q);
   wire        trigHit   =
      ((trigCond_q == `DTR_COND_THRESH) & thrHit) |
      ((trigCond_q == `DTR_COND_FAULT) & (faultPend_q | faultSync));
   wire        sampleTick = (dlyCnt_q == 3'h1) & recActive;
   wire        memWe      = sampleTick;
   wire [6:0]  wrPtrNext  = wrPtr_q + 7'h01;
   // Line 0 is the first post-event line, so a count of 1 ends at once
   wire        finishPre  = sampleTick & state_q[1] & trigHit &
                            (postLines_q <= 7'h01);
   wire        finishPost = sampleTick & state_q[2] & (postLeft_q == 7'h01);
   wire        finish     = finishPre | finishPost;
   wire        trigEvt    = sampleTick & state_q[1] & trigHit;

   dtr_line_mem u_mem (
      .sys_clk (sys_clk),
      .wrEn    (memWe),
      .wrAddr  (wrPtr_q),
      .wrLine  (capLine),
      .rdAddr  (endPtr_q + rdIdx_q + 7'h01),
      .rdLine  (rdLine)
   );

   // Current value of the addressed writable register, for byte merging
   always @* begin
      wrOk  = 1'b1;
      curWr = 32'h0;
      case (awAddr_q)
         `DTR_REG_CTRL:    curWr = {31'h0, startCtl_q};
         `DTR_REG_TRIG:    curWr = {22'h0, trigCond_q, 4'h0, trigSel_q};
         `DTR_REG_THRESH:  curWr = {16'h0, thresh_q};
         `DTR_REG_SAMPLE:  curWr = {25'h0, interval_q};
         `DTR_REG_POST:    curWr = {25'h0, postLines_q};
         `DTR_REG_SRCSEL:  curWr = srcSel_q;
         `DTR_REG_IRQMASK: curWr = {30'h0, irqMask_q};
         `DTR_REG_RDIDX:   curWr = {25'h0, rdIdx_q};
         `DTR_REG_RDREL:   curWr = 32'h0;
         default:          wrOk  = 1'b0;
      endcase
   end

   always @* begin
      rdOk  = 1'b1;
      rdVal = 32'h0;
      if (s_axi_araddr[7:5] == `DTR_DATA_PAGE) begin
         rdVal = {16'h0, rdLine[{s_axi_araddr[4:2], 4'h0} +: 16]};
      end else begin
         case (s_axi_araddr)
            `DTR_REG_CTRL:    rdVal = {31'h0, startCtl_q};
            `DTR_REG_TRIG:    rdVal = {22'h0, trigCond_q, 4'h0, trigSel_q};
            `DTR_REG_THRESH:  rdVal = {16'h0, thresh_q};
            `DTR_REG_SAMPLE:  rdVal = {25'h0, interval_q};
            `DTR_REG_POST:    rdVal = {25'h0, postLines_q};
            `DTR_REG_SRCSEL:  rdVal = srcSel_q;
            `DTR_REG_STATUS:  rdVal = {29'h0, trigPosValid_q, triggered_q,
                                       startCtl_q};
            `DTR_REG_TRIGPOS: rdVal = {25'h0, trigPos_q};
            `DTR_REG_COUNT:   rdVal = {24'h0, count_q};
            `DTR_REG_IRQSTAT: rdVal = {30'h0, irqStat_q};
            `DTR_REG_IRQMASK: rdVal = {30'h0, irqMask_q};
            `DTR_REG_RDIDX:   rdVal = {25'h0, rdIdx_q};
            `DTR_REG_RDREL:   rdVal = 32'h0;
            default:          rdOk  = 1'b0;
         endcase
      end
   end

   // AXI4-Lite handshakes
   always @(posedge sys_clk) begin
      if (srst) begin
         awReady_q <= 1'b0;
         wReady_q  <= 1'b0;
         awHeld_q  <= 1'b0;
         wHeld_q   <= 1'b0;
         awAddr_q  <= 8'h00;
         wData_q   <= 32'h0;
         wStrb_q   <= 4'h0;
         bValid_q  <= 1'b0;
         bResp_q   <= `DTR_RESP_OKAY;
         arReady_q <= 1'b0;
         rValid_q  <= 1'b0;
         rData_q   <= 32'h0;
         rResp_q   <= `DTR_RESP_OKAY;
      end else begin
         if (awTake) begin
            awAddr_q  <= {s_axi_awaddr[7:2], 2'h0};
            awHeld_q  <= 1'b1;
            awReady_q <= 1'b0;
         end else if (!awHeld_q && !bValid_q) begin
            awReady_q <= 1'b1;
         end
         if (wTake) begin
            wData_q  <= s_axi_wdata;
            wStrb_q  <= s_axi_wstrb;
            wHeld_q  <= 1'b1;
            wReady_q <= 1'b0;
         end else if (!wHeld_q && !bValid_q) begin
            wReady_q <= 1'b1;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bValid_q <= 1'b1;
            bResp_q  <= wrOk ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
         end else if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
         end
         if (arTake) begin
            arReady_q <= 1'b0;
            rValid_q  <= 1'b1;
            rData_q   <= rdVal;
            rResp_q   <= rdOk ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
         end else if (rValid_q && s_axi_rready) begin
            rValid_q  <= 1'b0;
            arReady_q <= 1'b1;
         end else if (!rValid_q) begin
            arReady_q <= 1'b1;
         end
      end
   end

   // Settings and interrupt registers
   always @(posedge sys_clk) begin
      if (srst) begin
         trigSel_q   <= 4'h0;
         trigCond_q  <= 2'h0;
         thresh_q    <= 16'h0;
         interval_q  <= `DTR_RST_INTERVAL;
         postLines_q <= `DTR_RST_POST;
         srcSel_q    <= `DTR_RST_SRCSEL;
         irqMask_q   <= 2'h0;
         irqStat_q   <= 2'h0;
         rdIdx_q     <= 7'h00;
         irq_q       <= 1'b0;
      end else begin
         if (doWrite && wrOk) begin
            case (awAddr_q)
               `DTR_REG_TRIG: begin
                  trigSel_q  <= wrVal[3:0];
                  trigCond_q <= wrVal[9:8];
               end
               `DTR_REG_THRESH:  thresh_q    <= wrVal[15:0];
               `DTR_REG_SAMPLE:  interval_q  <= wrVal[6:0];
               `DTR_REG_POST:    postLines_q <= wrVal[6:0];
               `DTR_REG_SRCSEL:  srcSel_q    <= wrVal;
               `DTR_REG_IRQMASK: irqMask_q   <= wrVal[1:0];
               `DTR_REG_RDIDX:   rdIdx_q     <= wrVal[6:0];
               `DTR_REG_RDREL:
                  rdIdx_q <= `DTR_IDX_MAX - postLines_q + wrVal[6:0];
               default: ;
            endcase
         end
         // New events win over the read that clears them
         irqStat_q <= (irqStat_q &
                       ~{2{arTake && (s_axi_araddr == `DTR_REG_IRQSTAT)}}) |
                      {finish, trigEvt};
         irq_q <= |(irqStat_q & irqMask_q);
      end
   end

   // Sampling divider: the strobe is counted, the write lags by a fixed delay
   always @(posedge sys_clk) begin
      if (srst || arm || !recActive) begin
         divCnt_q <= 7'h00;
         dlyCnt_q <= 3'h0;
      end else begin
         if (fireStrobe) begin
            if (divCnt_q + 7'h01 >= intervalEff) begin
               divCnt_q <= 7'h00;
               dlyCnt_q <= `DTR_SAMPLE_DLY_CYC;
            end else begin
               divCnt_q <= divCnt_q + 7'h01;
            end
         end
         if (dlyCnt_q != 3'h0 && !(fireStrobe &&
             divCnt_q + 7'h01 >= intervalEff)) begin
            dlyCnt_q <= dlyCnt_q - 3'h1;
         end
      end
   end

   // Recorder sequence
   always @(posedge sys_clk) begin
      if (srst) begin
         state_q        <= ST_IDLE;
         startCtl_q     <= 1'b0;
         wrPtr_q        <= 7'h00;
         endPtr_q       <= 7'h00;
         postLeft_q     <= 7'h00;
         count_q        <= 8'h00;
         trigPos_q      <= 7'h00;
         trigPosValid_q <= 1'b0;
         triggered_q    <= 1'b0;
         cfgDirty_q     <= 1'b0;
         faultPend_q    <= 1'b0;
      end else begin
         if (cfgWr && recActive) begin
            cfgDirty_q <= 1'b1;
         end
         if (faultSync && state_q[1]) begin
            faultPend_q <= 1'b1;
         end
         case (state_q)
            ST_IDLE: begin
               if (arm) begin
                  state_q        <= ST_PRE;
                  startCtl_q     <= 1'b1;
                  wrPtr_q        <= 7'h00;
                  count_q        <= 8'h00;
                  trigPosValid_q <= 1'b0;
                  triggered_q    <= 1'b0;
                  cfgDirty_q     <= 1'b0;
                  faultPend_q    <= 1'b0;
               end
            end
            ST_PRE, ST_POST: begin
               if (abort) begin
                  state_q        <= ST_IDLE;
                  startCtl_q     <= 1'b0;
                  endPtr_q       <= wrPtr_q;
                  trigPosValid_q <= 1'b0;
               end else if (sampleTick) begin
                  wrPtr_q <= wrPtrNext;
                  if (count_q != `DTR_DEPTH) begin
                     count_q <= count_q + 8'h01;
                  end
                  if (finish) begin
                     state_q        <= ST_IDLE;
                     startCtl_q     <= 1'b0;
                     endPtr_q       <= wrPtrNext;
                     trigPos_q      <= `DTR_IDX_MAX - postLines_q;
                     trigPosValid_q <= ~cfgDirty_q;
                  end else if (trigEvt) begin
                     state_q     <= ST_POST;
                     postLeft_q  <= postLines_q - 7'h01;
                  end else if (state_q[2]) begin
                     postLeft_q  <= postLeft_q - 7'h01;
                  end
                  if (trigEvt) begin
                     triggered_q <= 1'b1;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign s_axi_awready = awReady_q;
   assign s_axi_wready  = wReady_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;
   assign s_axi_rvalid  = rValid_q;
   assign irq           = irq_q;
endmodule // dtr_recorder

// ==== verif/dtr_recorder_chk.sv ====
`timescale 1ns/100ps
module dtr_recorder_chk (
   input wire         sys_clk,
   input wire         srst,
   input wire [7:0]   s_axi_awaddr,
   input wire         s_axi_awvalid,
   input wire         s_axi_awready,
   input wire         s_axi_wvalid,
   input wire         s_axi_wready,
   input wire [1:0]   s_axi_bresp,
   input wire         s_axi_bvalid,
   input wire         s_axi_bready,
   input wire [7:0]   s_axi_araddr,
   input wire         s_axi_arvalid,
   input wire         s_axi_arready,
   input wire [31:0]  s_axi_rdata,
   input wire [1:0]   s_axi_rresp,
   input wire         s_axi_rvalid,
   input wire         s_axi_rready,
   input wire         irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   wire wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire rTake = s_axi_arvalid && s_axi_arready;
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   a_wr_answer: assert property (wTake |=> !s_axi_awready && !s_axi_wready
      ##1 s_axi_bvalid) else $error("write answer late");
   a_rd_answer: assert property (rTake |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_rd_unmapped: assert property (rTake && s_axi_araddr >= 8'h60 |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad rresp");
   a_wr_readonly: assert property (wTake && s_axi_awaddr == 8'h18 |=>
      ##1 s_axi_bresp == 2'h2) else $error("status write accepted");
   a_wr_ctrl_ok: assert property (wTake && s_axi_awaddr == 8'h00 |=>
      ##1 s_axi_bresp == 2'h0) else $error("control write refused");
   a_reset_quiet: assert property ($fell(srst) |-> !s_axi_bvalid &&
      !s_axi_rvalid && !irq && !s_axi_arready) else $error("not idle");
   c_rd_err: cover property (rTake && s_axi_araddr >= 8'h60);
   c_wr_err: cover property (wTake && s_axi_awaddr == 8'h18);
   c_irq_up: cover property ($rose(irq));
endmodule // dtr_recorder_chk

// ==== verif/dtr_sig_model.sv ====
`timescale 1ns/100ps
module dtr_sig_model #(
   parameter int PER = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic [15:0]  trigLvl,
   input  wire logic         faultReq,
   output logic              fireStrobe,
   output logic [255:0]      sigBus,
   output logic              faultPin
);
   logic [3:0]  div_q;
   logic [7:0]  cnt_q;
   logic [15:0] lvl_q;
   // Fault message is asynchronous like the real source
   assign faultPin = faultReq;
   always @(posedge sys_clk) begin
      if (srst) begin
         div_q <= 4'h0;
         fireStrobe <= 1'h0;
         cnt_q <= 8'h0;
         lvl_q <= 16'h0;
      end else begin
         div_q <= (div_q == PER - 1) ? 4'h0 : div_q + 4'h1;
         fireStrobe <= (div_q == PER - 1);
         if (fireStrobe) begin
            cnt_q <= cnt_q + 8'h1;
            lvl_q <= trigLvl;
         end
      end
   end
   always_comb begin
      for (int n = 0; n < 15; n++)
         sigBus[16*n +: 16] = {4'(n), 4'h0, cnt_q};
      // Changes only at a strobe, so it stands over the sample point
      sigBus[255:240] = lvl_q;
   end
endmodule // dtr_sig_model

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic         sys_clk = 1'h0;
   logic         srst = 1'h1;
   logic [7:0]   s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0]  s_axi_wdata = 32'h0;
   logic [3:0]   s_axi_wstrb = 4'hf;
   logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic         s_axi_rready = 1'h0, faultReq = 1'h0;
   logic [15:0]  trigLvl = 16'h100;
   wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire          s_axi_rvalid, irq, fireStrobe, faultPin;
   wire [1:0]    s_axi_bresp, s_axi_rresp;
   wire [31:0]   s_axi_rdata;
   wire [255:0]  sigBus;
   int           err_total = 0, checks = 0;
   logic [31:0]  d;
   logic [1:0]   r;
   logic [7:0]   e0;
   dtr_recorder dut_u (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fireStrobe, .sigBus,
      .faultPin, .irq);
   dtr_sig_model #(.PER(8)) far_u (.sys_clk, .srst, .trigLvl, .faultReq,
      .fireStrobe, .sigBus, .faultPin);
   always #12.5 sys_clk = ~sys_clk;
   task stop_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks++;
      if (seen !== ex) begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, ex, seen);
      end
   endtask
   // Leading edge keeps a release and a new request out of one time step
   task wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         n++;
      end while (s_axi_bvalid !== 1'h1 && n < 100);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (n >= 100) chk("write wait", 0, 1);
   endtask
   task rd(input logic [7:0] a);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         n++;
      end while (s_axi_rvalid !== 1'h1 && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n >= 100) chk("read wait", 0, 1);
   endtask
   task wait_done;
      int n;
      n = 0;
      do begin
         rd(8'h00);
         n++;
      end while (d[0] !== 1'h0 && n < 3000);
      chk("start cleared", d[0], 0);
   endtask
   // Channel 0 was pointed at signal 9, the others at their own index
   task ln(input int rel, input logic [7:0] e);
      wr(8'h30, 32'(rel));
      for (int k = 0; k < 8; k++) begin
         rd(8'h40 + 8'(4 * k));
         chk("line", d, {16'h0, 4'(k == 0 ? 9 : k), 4'h0, e});
      end
   endtask
   task t_reset;
      rd(8'h0c);
      chk("interval", d, 32'h1);
      rd(8'h10);
      chk("post", d, 32'ha);
      rd(8'h14);
      chk("sources", d, 32'h76543210);
      rd(8'h7c);
      chk("unmapped", r, 2'h2);
      wr(8'h18, 32'h1);
      chk("ro write", r, 2'h2);
      $display("reset test done");
   endtask
   task t_thresh;
      int n;
      wr(8'h14, 32'h76543219);
      wr(8'h04, 32'h20f);
      wr(8'h08, 32'h100);
      wr(8'h0c, 32'h1);
      wr(8'h10, 32'ha);
      wr(8'h28, 32'h3);
      wr(8'h00, 32'h1);
      chk("ctrl ok", r, 2'h0);
      repeat (1600) @(posedge sys_clk);
      rd(8'h18);
      chk("equal no fire", d[1], 0);
      trigLvl <= 16'h101;
      n = 0;
      while (sigBus[255:240] !== 16'h101 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      e0 = sigBus[7:0];
      wait_done;
      rd(8'h24);
      chk("irq status", d[1:0], 2'h3);
      repeat (3) @(posedge sys_clk);
      chk("irq cleared", irq, 0);
      rd(8'h18);
      chk("pos valid", d[2], 1);
      rd(8'h20);
      chk("count", d, 32'd128);
      rd(8'h1c);
      chk("trig pos", d, 32'd117);
      ln(0, e0);
      rd(8'h2c);
      chk("raw index", d, 32'd117);
      ln(-1, e0 - 8'd1);
      ln(9, e0 + 8'd9);
      ln(-118, e0 - 8'd118);
      $display("threshold test done");
   endtask
   task t_fault;
      logic [7:0] ef;
      wr(8'h04, 32'h30f);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h6);
      wr(8'h10, 32'h5);
      wr(8'h00, 32'h1);
      repeat (6400) @(posedge sys_clk);
      rd(8'h18);
      chk("no fault no fire", d[1:0], 2'h1);
      ef = sigBus[7:0];
      faultReq <= 1'h1;
      repeat (4) @(posedge sys_clk);
      faultReq <= 1'h0;
      wait_done;
      rd(8'h1c);
      chk("trig pos", d, 32'd122);
      wr(8'h30, 32'h0);
      rd(8'h44);
      e0 = d[7:0];
      chk("fault line", 8'(e0 - ef) <= 8'd6, 1);
      ln(-1, e0 - 8'd6);
      ln(4, e0 + 8'd24);
      ln(-123, e0 - 8'd226);
      $display("fault test done");
   endtask
   task t_order;
      wr(8'h04, 32'h20f);
      wr(8'h08, 32'h100);
      wr(8'h10, 32'h3);
      wr(8'h28, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h0c, 32'h1);
      wait_done;
      rd(8'h20);
      chk("count at arm", d, 32'd3);
      rd(8'h18);
      chk("late config", d[2], 0);
      chk("masked irq", irq, 0);
      rd(8'h24);
      chk("masked status", d[1], 1);
      wr(8'h08, 32'h7fff);
      wr(8'h28, 32'h3);
      wr(8'h00, 32'h1);
      repeat (100) @(posedge sys_clk);
      wr(8'h00, 32'h0);
      rd(8'h18);
      chk("abort", {d[2], d[0]}, 2'h0);
      repeat (40) @(posedge sys_clk);
      chk("abort no irq", irq, 0);
      $display("order test done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      srst <= 1'h0;
      @(posedge sys_clk);
      t_reset;
      t_thresh;
      t_fault;
      t_order;
      stop_test;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_total++;
      $display("BAD watchdog exp done seen hang");
      stop_test;
   end
endmodule // testbench
bind dtr_recorder dtr_recorder_chk chk_u (.sys_clk, .srst, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .irq);
